/* File: hdl/ipv4_route.sv */
// IPv4 forwarding decision stage: validates a parsed header, decides local
// delivery, forwarding or drop, rewrites TTL and checksum, picks source MAC.
// Assumes headers arrive already translated when received from the operator.
`timescale 1ns/1ps

module ipv4_route
  import ipv4_route_pkg::*;
#(
  parameter int N_SUB = 2
) (
  input  wire logic                   ref_clk_i,
  input  wire logic                   reset_n_i,
  input  wire logic                   pkt_valid_i,
  input  wire pkt_desc_t              pkt_i,
  input  wire logic [31:0]            public_addr_i,
  input  wire logic [31:0]            op_mask_i,
  input  wire logic [N_SUB-1:0][31:0] cust_addr_i,
  input  wire logic [N_SUB-1:0][31:0] cust_mask_i,
  input  wire logic [N_SUB-1:0]       cust_en_i,
  input  wire logic [31:0]            default_rtr_i,
  input  wire logic                   default_rtr_en_i,
  input  wire logic [31:0]            inner_rtr_addr_i,
  input  wire logic                   inner_rtr_en_i,
  input  wire logic                   dual_mode_i,
  input  wire logic                   link_ident_en_i,
  input  wire logic [15:0]            delegated_link_identifier_i,
  input  wire logic [7:0]             delegated_prefix_lease_len_i,
  input  wire logic [47:0]            op_mac_i,
  input  wire logic [47:0]            cust_mac_i,
  output logic                        pkt_ready_o,
  output logic                        dec_valid_o,
  output route_dec_t                  dec_o,
  output logic                        inner_route_valid_o,
  output logic [31:0]                 inner_route_prefix_o,
  output logic [7:0]                  inner_route_len_o,
  output logic [31:0]                 inner_route_next_hop_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Header checksum helper.

  function automatic logic [15:0] hdr_fold(input ipv4_hdr_t h);
    logic [19:0] acc;
    logic [159:0] flat;
    acc = 20'h00000;
    flat = h;
    for (int w = 0; w < 10; w++) begin
      acc = acc + {4'h0, flat[w*16 +: 16]};
    end
    acc = {4'h0, acc[15:0]} + {16'h0000, acc[19:16]};
    acc = {4'h0, acc[15:0]} + {16'h0000, acc[19:16]};
    return acc[15:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State and pipeline registers.

  route_st_t   state_reg;
  route_st_t   state_next;
  pkt_desc_t   pkt_reg;
  logic        hdr_ok_reg;
  route_dec_t  dec_reg;
  route_dec_t  dec_next;
  logic        dec_valid_reg;
  logic        ready_reg;
  logic [31:0] inner_prefix_reg;
  logic [7:0]  inner_len_reg;
  logic        inner_valid_reg;
  logic [31:0] inner_nh_reg;

  ipv4_hdr_t   hdr;
  ipv4_hdr_t   hdr_new;
  assign hdr = pkt_reg.hdr;

  wire accept = pkt_valid_i && state_reg == ST_IDLE;

  always_comb begin
    case (state_reg)
      ST_IDLE:  state_next = accept ? ST_CHECK : ST_IDLE;
      ST_CHECK: state_next = ST_ROUTE;
      ST_ROUTE: state_next = ST_EMIT;
      ST_EMIT:  state_next = ST_IDLE;
      default:  state_next = ST_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Header validation, done in its own cycle ahead of any lookup.

  wire hdr_len_ok = hdr.total_len >= {10'h000, hdr.ihl, 2'b00} &&
                    pkt_reg.frame_len >= HDR_BYTES_MIN &&
                    pkt_reg.frame_len >= hdr.total_len;
  wire hdr_ok = hdr.version == IP_VERSION && hdr.ihl >= IHL_MIN &&
                hdr_len_ok && hdr_fold(hdr) == CSUM_GOOD;

  ////////////////////////////////////////////////////////////////////////////
  // Address classification.

  logic [N_SUB-1:0] sub_hit;
  logic [N_SUB-1:0] own_hit;
  logic [N_SUB-1:0] dir_bc_hit;

  for (genvar i = 0; i < N_SUB; i++) begin : g_sub
    assign sub_hit[i] = cust_en_i[i] &&
      (hdr.dst & cust_mask_i[i]) == (cust_addr_i[i] & cust_mask_i[i]);
    assign own_hit[i] = cust_en_i[i] && hdr.dst == cust_addr_i[i];
    assign dir_bc_hit[i] = sub_hit[i] &&
      (hdr.dst | cust_mask_i[i]) == ADDR_ALL_ONES;
  end

  wire dst_mcast = hdr.dst[31:28] == MCAST_NIBBLE;
  wire dst_bcast = hdr.dst == ADDR_ALL_ONES || pkt_reg.l2_bcast ||
                   (|dir_bc_hit) ||
                   (hdr.dst | op_mask_i) == ADDR_ALL_ONES;
  wire op_hit = (hdr.dst & op_mask_i) == (public_addr_i & op_mask_i);

  wire [7:0] inner_len_calc = delegated_prefix_lease_len_i - V6_TO_V4_LEN;
  wire inner_len_ok = delegated_prefix_lease_len_i >= V6_TO_V4_LEN &&
                      inner_len_calc <= V4_LEN_MAX;
  wire [31:0] inner_mask = ~(ADDR_ALL_ONES >> inner_len_reg[5:0]);
  // The derived prefix keeps the low link byte, so both sides are masked.
  wire inner_hit = inner_valid_reg &&
                   (hdr.dst & inner_mask) == (inner_prefix_reg & inner_mask);

  wire is_icmp = hdr.proto == PROTO_ICMP;
  wire is_icmp_err = is_icmp && (pkt_reg.icmp_type == ICMP_DEST_UNR ||
                     pkt_reg.icmp_type == ICMP_SRC_QUENCH ||
                     pkt_reg.icmp_type == ICMP_REDIRECT ||
                     pkt_reg.icmp_type == ICMP_TIME_EXC ||
                     pkt_reg.icmp_type == ICMP_PARAM_PRB);
  wire src_bad = hdr.src == ADDR_ZERO || hdr.src[31:24] == LOOPBACK_NET ||
                 hdr.src[31:28] == MCAST_NIBBLE ||
                 hdr.src[31:28] == CLASS_E_NIBBLE;
  wire icmp_quiet = pkt_reg.congested || is_icmp_err ||
                    dst_bcast || dst_mcast ||
                    src_bad || hdr.frag_off != 13'h0000;

  wire to_local = pkt_reg.from_cust ? (|own_hit)
                                    : hdr.dst == public_addr_i;

  ////////////////////////////////////////////////////////////////////////////
  // Next-hop resolution per ingress side.

  logic        nh_found;
  logic        egress_op;
  logic [31:0] nh_addr;

  always_comb begin
    nh_found  = 1'b1;
    egress_op = 1'b0;
    nh_addr   = hdr.dst;
    if (|sub_hit) begin
      nh_addr = hdr.dst;
    end else if (inner_hit) begin
      nh_addr = inner_rtr_addr_i;
    end else if (!pkt_reg.from_cust) begin
      nh_found = inner_rtr_en_i;
      nh_addr  = inner_rtr_addr_i;
    end else if (op_hit) begin
      egress_op = 1'b1;
    end else begin
      egress_op = 1'b1;
      nh_found  = default_rtr_en_i;
      nh_addr   = default_rtr_i;
    end
  end

  always_comb begin
    hdr_new = hdr;
    hdr_new.ttl = hdr.ttl - TTL_DEC;
    hdr_new.csum = 16'h0000;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decision. Operator-side packets are already translated upstream, so
  // only address resolution follows them; one that matches no customer subnet
  // goes to the inner router, and is dropped when inner_rtr_en_i is low.

  logic want_icmp;

  always_comb begin
    dec_next = '0;
    want_icmp = 1'b0;
    dec_next.action = ACT_DROP;
    dec_next.ttl = hdr.ttl;
    dec_next.csum = hdr.csum;
    dec_next.next_hop = nh_addr;
    if (!hdr_ok_reg) begin
      dec_next.action = ACT_DROP;
    end else if (dst_bcast || dst_mcast || to_local) begin
      dec_next.action = ACT_LOCAL;
      if (is_icmp && pkt_reg.icmp_type == ICMP_ECHO_REQ && to_local) begin
        dec_next.icmp_gen = 1'b1;
        dec_next.icmp_type = ICMP_ECHO_REPLY;
      end
    end else if (pkt_reg.congested) begin
      dec_next.action = ACT_DROP;
    end else if (!nh_found || (!pkt_reg.from_cust && egress_op)) begin
      want_icmp = 1'b1;
      dec_next.icmp_type = ICMP_DEST_UNR;
      dec_next.icmp_code = ICMP_CODE_NET;
    end else if (hdr.ttl <= TTL_DEC) begin
      want_icmp = 1'b1;
      dec_next.icmp_type = ICMP_TIME_EXC;
      dec_next.icmp_code = ICMP_CODE_TTL;
    end else begin
      dec_next.action = egress_op ? ACT_FWD_OP : ACT_FWD_CU;
      dec_next.ttl = hdr_new.ttl;
      dec_next.csum = ~hdr_fold(hdr_new);
      dec_next.src_mac = egress_op ? op_mac_i
                                   : cust_mac_i;
      dec_next.needs_napt = egress_op && pkt_reg.from_cust;
      dec_next.needs_arp = 1'b1;
    end
    if (want_icmp) begin
      dec_next.icmp_gen = !icmp_quiet &&
        !(dec_next.icmp_type == ICMP_DEST_UNR && !pkt_reg.from_cust);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers. The MAC inputs are shared by both address families, so a
  // single pair of source addresses serves all egress frames.

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      state_reg <= ST_IDLE;
      pkt_reg <= '0;
      hdr_ok_reg <= 1'b0;
      dec_reg <= '0;
      dec_valid_reg <= 1'b0;
      ready_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      ready_reg <= state_next == ST_IDLE;
      dec_valid_reg <= state_next == ST_EMIT;
      if (accept) begin
        pkt_reg <= pkt_i;
      end
      if (state_reg == ST_CHECK) begin
        hdr_ok_reg <= hdr_ok;
      end
      if (state_reg == ST_ROUTE) begin
        dec_reg <= dec_next;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      inner_valid_reg <= 1'b0;
      inner_prefix_reg <= '0;
      inner_len_reg <= '0;
      inner_nh_reg <= '0;
    end else begin
      inner_nh_reg <= inner_rtr_addr_i;
      inner_valid_reg <= dual_mode_i && link_ident_en_i && inner_rtr_en_i &&
                         inner_len_ok;
      inner_prefix_reg <= {INNER_FIRST_OCTET,
                           delegated_link_identifier_i, 8'h00};
      inner_len_reg <= inner_len_calc;
    end
  end

  assign pkt_ready_o = ready_reg;
  assign dec_valid_o = dec_valid_reg;
  assign dec_o = dec_reg;
  assign inner_route_valid_o = inner_valid_reg;
  assign inner_route_prefix_o = inner_prefix_reg;
  assign inner_route_len_o = inner_len_reg;
  assign inner_route_next_hop_o = inner_nh_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);

  wire dec_fwd = dec_valid_reg && (dec_reg.action == ACT_FWD_OP ||
                                   dec_reg.action == ACT_FWD_CU);
  wire dec_drop = dec_valid_reg && dec_reg.action == ACT_DROP;

  // Outgoing header as the decision leaves it. A valid checksum folds to
  // all ones, whatever way the logic above arrived at it.
  ipv4_hdr_t out_hdr;

  always_comb begin
    out_hdr = pkt_reg.hdr;
    out_hdr.ttl = dec_reg.ttl;
    out_hdr.csum = dec_reg.csum;
  end

  a_check_before_route: assert property (
    accept |=> state_reg == ST_CHECK ##1 state_reg == ST_ROUTE
    ##1 dec_valid_reg)
    else $error("decision not three cycles after accept");
  a_fwd_ttl_dec: assert property (
    dec_fwd |-> dec_reg.ttl == pkt_reg.hdr.ttl - TTL_DEC)
    else $error("forwarded ttl not decremented");
  a_local_ttl_kept: assert property (
    dec_valid_reg && dec_reg.action == ACT_LOCAL
    |-> dec_reg.ttl == pkt_reg.hdr.ttl)
    else $error("local ttl changed");
  a_public_local: assert property (
    dec_valid_reg && hdr_ok_reg && !pkt_reg.from_cust &&
    pkt_reg.hdr.dst == public_addr_i |-> dec_reg.action == ACT_LOCAL)
    else $error("public address not delivered locally");
  a_bcast_local: assert property (
    dec_valid_reg && hdr_ok_reg && pkt_reg.hdr.dst == ADDR_ALL_ONES
    |-> dec_reg.action == ACT_LOCAL)
    else $error("broadcast forwarded");
  a_frag_quiet: assert property (
    dec_drop && pkt_reg.hdr.frag_off != 13'h0000 |-> !dec_reg.icmp_gen)
    else $error("icmp for later fragment");
  a_err_quiet: assert property (
    dec_drop && is_icmp_err |-> !dec_reg.icmp_gen)
    else $error("icmp about icmp error");
  a_no_unreach_op: assert property (
    dec_valid_reg && !pkt_reg.from_cust && dec_reg.icmp_gen
    |-> dec_reg.icmp_type != ICMP_DEST_UNR)
    else $error("unreachable toward operator");
  a_src_mac_sel: assert property (
    dec_fwd |-> dec_reg.src_mac ==
    (dec_reg.action == ACT_FWD_OP ? op_mac_i : cust_mac_i))
    else $error("wrong source mac");
  a_csum_valid: assert property (
    dec_fwd |-> hdr_fold(out_hdr) == CSUM_GOOD)
    else $error("checksum not recomputed");
  a_inner_len: assert property (
    $past(reset_n_i) && $past(dual_mode_i && link_ident_en_i &&
    inner_rtr_en_i && inner_len_ok) |-> inner_valid_reg &&
    inner_len_reg == $past(delegated_prefix_lease_len_i) - V6_TO_V4_LEN)
    else $error("inner route length wrong");

  c_fwd_op: cover property (dec_valid_reg && dec_reg.action == ACT_FWD_OP);
  c_fwd_cu: cover property (dec_valid_reg && dec_reg.action == ACT_FWD_CU);
  c_local: cover property (dec_valid_reg && dec_reg.action == ACT_LOCAL);
  c_drop_icmp: cover property (dec_valid_reg && dec_reg.action == ACT_DROP
    && dec_reg.icmp_gen);

endmodule

/* File: hdl/ipv4_route_pkg.sv */
// Package for the IPv4 forwarding decision block: header and descriptor
// layouts, decision encodings, ICMP codes and address constants.
// Assumes the surrounding datapath parses headers into these structs.
package ipv4_route_pkg;

  localparam logic [3:0]  IP_VERSION     = 4'h4;
  localparam logic [3:0]  IHL_MIN        = 4'h5;
  localparam logic [15:0] HDR_BYTES_MIN  = 16'h0014;
  localparam logic [7:0]  PROTO_ICMP     = 8'h01;
  localparam logic [7:0]  TTL_DEC        = 8'h01;
  localparam logic [7:0]  ICMP_ECHO_REPLY = 8'h00;
  localparam logic [7:0]  ICMP_DEST_UNR  = 8'h03;
  localparam logic [7:0]  ICMP_SRC_QUENCH = 8'h04;
  localparam logic [7:0]  ICMP_REDIRECT  = 8'h05;
  localparam logic [7:0]  ICMP_ECHO_REQ  = 8'h08;
  localparam logic [7:0]  ICMP_TIME_EXC  = 8'h0b;
  localparam logic [7:0]  ICMP_PARAM_PRB = 8'h0c;
  localparam logic [7:0]  ICMP_CODE_NET  = 8'h00;
  localparam logic [7:0]  ICMP_CODE_TTL  = 8'h00;
  localparam logic [31:0] ADDR_ALL_ONES  = 32'hffffffff;
  localparam logic [31:0] ADDR_ZERO      = 32'h00000000;
  localparam logic [7:0]  LOOPBACK_NET   = 8'h7f;
  localparam logic [3:0]  MCAST_NIBBLE   = 4'he;
  localparam logic [3:0]  CLASS_E_NIBBLE = 4'hf;
  localparam logic [7:0]  INNER_FIRST_OCTET = 8'h0a;
  localparam logic [7:0]  V6_TO_V4_LEN   = 8'h28;
  localparam logic [7:0]  V4_LEN_MAX     = 8'h20;
  localparam logic [15:0] CSUM_GOOD      = 16'hffff;

  typedef struct packed {
    logic [3:0]  version;
    logic [3:0]  ihl;
    logic [7:0]  tos;
    logic [15:0] total_len;
    logic [15:0] ident;
    logic [2:0]  flags;
    logic [12:0] frag_off;
    logic [7:0]  ttl;
    logic [7:0]  proto;
    logic [15:0] csum;
    logic [31:0] src;
    logic [31:0] dst;
  } ipv4_hdr_t;

  typedef struct packed {
    ipv4_hdr_t   hdr;
    logic [15:0] frame_len;
    logic [7:0]  icmp_type;
    logic        from_cust;
    logic        l2_bcast;
    logic        congested;
  } pkt_desc_t;

  typedef enum logic [1:0] {
    ACT_DROP   = 2'h0,
    ACT_LOCAL  = 2'h1,
    ACT_FWD_OP = 2'h2,
    ACT_FWD_CU = 2'h3
  } route_act_t;

  typedef struct packed {
    route_act_t  action;
    logic [31:0] next_hop;
    logic [7:0]  ttl;
    logic [15:0] csum;
    logic [47:0] src_mac;
    logic        needs_napt;
    logic        needs_arp;
    logic        icmp_gen;
    logic [7:0]  icmp_type;
    logic [7:0]  icmp_code;
  } route_dec_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_CHECK = 2'b01,
    ST_ROUTE = 2'b11,
    ST_EMIT  = 2'b10
  } route_st_t;

endpackage

/* File: dv/lan_host_model.sv */
// Far-side packet source for the forwarding stage: offers one descriptor
// per request and keeps it steady until the stage takes it.
// Assumes requests arrive as one-cycle pulses on the stage's clock.
`timescale 1ns/1ps

module lan_host_model
  import ipv4_route_pkg::*;
(
  input  wire logic      ref_clk_i,
  input  wire logic      reset_n_i,
  input  wire logic      send_i,
  input  wire pkt_desc_t desc_i,
  input  wire logic      ready_i,
  output logic           valid_o,
  output pkt_desc_t      pkt_o
);
  // Once taken, the descriptor is replaced by its inverse, so a stage that
  // samples it late sees a wrong value rather than a stale copy.
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      valid_o <= 1'b0;
      pkt_o   <= '0;
    end else if (valid_o && ready_i) begin
      valid_o <= 1'b0;
      pkt_o   <= ~pkt_o;
    end else if (send_i) begin
      valid_o <= 1'b1;
      pkt_o   <= desc_i;
    end
  end
endmodule

/* File: dv/ipv4_route_bench.sv */
// Self-checking bench for the IPv4 forwarding decision stage.
// Assumes the stage answers each taken descriptor with one decision.
`timescale 1ns/1ps

module ipv4_route_bench
  import ipv4_route_pkg::*;
;
  logic                 ref_clk_i    = 1'b0;
  logic                 reset_n_i    = 1'b0;
  logic                 send_req     = 1'b0;
  pkt_desc_t            desc         = '0;
  pkt_desc_t            cur          = '0;
  logic [31:0]          public_addr  = 32'hc6336405;
  logic [1:0][31:0]     cust_addr    = {32'hc0a80101, 32'hc0a80001};
  logic [1:0][31:0]     cust_mask    = {32'hffffff00, 32'hffffff00};
  logic [1:0]           cust_en      = 2'h3;
  logic [31:0]          default_rtr  = 32'hc6336401;
  logic                 def_rtr_en   = 1'b1;
  logic [31:0]          inner_addr   = 32'hc0a80002;
  logic                 inner_en     = 1'b1;
  logic                 link_en      = 1'b1;
  logic                 dual_mode    = 1'b1;
  logic [15:0]          delegated_link_identifier      = 16'h5601;
  logic [7:0]           lease_len    = 8'h3c;
  logic [47:0]          op_mac       = 48'h02aa00000001;
  logic [47:0]          cust_mac     = 48'h02bb00000002;
  logic                 pkt_valid;
  pkt_desc_t            pkt;
  logic                 pkt_ready;
  logic                 dec_valid;
  route_dec_t           dec;
  logic                 ir_valid;
  logic [31:0]          ir_prefix;
  logic [7:0]           ir_len;
  logic [31:0]          ir_nh;
  int                   failures     = 0;
  int                   n_checks     = 0;

  initial begin
    forever #20 ref_clk_i = ~ref_clk_i;
  end

  lan_host_model host (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
    .send_i(send_req), .desc_i(desc), .ready_i(pkt_ready),
    .valid_o(pkt_valid), .pkt_o(pkt));

  ipv4_route #(.N_SUB(2)) uut (.ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i), .pkt_valid_i(pkt_valid), .pkt_i(pkt),
    .public_addr_i(public_addr), .op_mask_i(32'hffffff00),
    .cust_addr_i(cust_addr), .cust_mask_i(cust_mask), .cust_en_i(cust_en),
    .default_rtr_i(default_rtr), .default_rtr_en_i(def_rtr_en),
    .inner_rtr_addr_i(inner_addr), .inner_rtr_en_i(inner_en),
    .dual_mode_i(dual_mode), .link_ident_en_i(link_en),
    .delegated_link_identifier_i(delegated_link_identifier),
    .delegated_prefix_lease_len_i(lease_len), .op_mac_i(op_mac),
    .cust_mac_i(cust_mac), .pkt_ready_o(pkt_ready), .dec_valid_o(dec_valid),
    .dec_o(dec), .inner_route_valid_o(ir_valid),
    .inner_route_prefix_o(ir_prefix), .inner_route_len_o(ir_len),
    .inner_route_next_hop_o(ir_nh));

///////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] hdr_sum(ipv4_hdr_t h);
    logic [159:0] b;
    logic [31:0]  s;
    b = h;
    b[79:64] = 16'h0000;
    s = 32'h00000000;
    for (int i = 0; i < 10; i++) begin
      s = s + 32'(b[159-16*i -: 16]);
    end
    s = 32'(s[15:0]) + 32'(s[31:16]);
    s = 32'(s[15:0]) + 32'(s[31:16]);
    return ~s[15:0];
  endfunction

  function automatic pkt_desc_t mk(logic cu, logic [31:0] dst,
                                   logic [7:0] ttl);
    pkt_desc_t d;
    d = '0;
    d.hdr.version   = IP_VERSION;
    d.hdr.ihl       = IHL_MIN;
    d.hdr.total_len = 16'h0028;
    d.hdr.ttl       = ttl;
    d.hdr.proto     = 8'h11;
    d.hdr.src       = cu ? 32'hc0a80005 : 32'h08080808;
    d.hdr.dst       = dst;
    d.hdr.csum      = hdr_sum(d.hdr);
    d.frame_len     = 16'h0040;
    d.from_cust     = cu;
    return d;
  endfunction

  task automatic chk(logic [47:0] got, logic [47:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Waits a bounded time; the answer shows after the second edge following
  // the taking edge, and ready comes back one edge later.
  task automatic send(pkt_desc_t d);
    int k;
    cur = d;
    @(posedge ref_clk_i);
    desc <= d;
    send_req <= 1'b1;
    @(posedge ref_clk_i);
    send_req <= 1'b0;
    for (k = 0; k < 12; k++) begin
      @(posedge ref_clk_i);
      #1;
      if (dec_valid === 1'b1) break;
    end
    chk(k, 2);
    chk(pkt_ready, 1'b0);
    if (k == 12) test_done();
    @(posedge ref_clk_i);
    #1;
    chk({dec_valid, pkt_ready}, 2'b01);
  endtask

  task automatic expect_dec(route_act_t act, logic [31:0] nh, logic gen,
                            logic [7:0] ty);
    ipv4_hdr_t   h;
    logic [47:0] mac;
    h = cur.hdr;
    mac = (act == ACT_FWD_OP) ? op_mac : cust_mac;
    chk(dec.action, act);
    chk(dec.icmp_gen, gen);
    if (gen) begin
      chk(dec.icmp_type, ty);
      chk(dec.icmp_code, 8'h00);
    end
    if (act == ACT_LOCAL) chk(dec.ttl, h.ttl);
    if (act == ACT_FWD_OP || act == ACT_FWD_CU) begin
      h.ttl = h.ttl - 8'h01;
      chk(dec.next_hop, nh);
      chk(dec.ttl, h.ttl);
      chk(dec.csum, hdr_sum(h));
      chk(dec.needs_arp, 1'b1);
      chk(dec.needs_napt, act == ACT_FWD_OP);
      chk(dec.src_mac, mac);
    end
  endtask

///////////////////////////////////////////////////////////////////////////////
  task automatic t_local();
    pkt_desc_t d;
    send(mk(1'b0, public_addr, 8'h40));
    expect_dec(ACT_LOCAL, 32'h0, 1'b0, 8'h00);
    send(mk(1'b1, 32'hc0a80101, 8'h40));
    expect_dec(ACT_LOCAL, 32'h0, 1'b0, 8'h00);
    d = mk(1'b1, 32'hc0a80001, 8'h40);
    d.hdr.proto = PROTO_ICMP;
    d.icmp_type = ICMP_ECHO_REQ;
    d.hdr.csum = hdr_sum(d.hdr);
    send(d);
    expect_dec(ACT_LOCAL, 32'h0, 1'b1, 8'h00);
    $display("test local delivery done");
  endtask

  task automatic t_from_op();
    send(mk(1'b0, 32'hc0a80105, 8'h40));
    expect_dec(ACT_FWD_CU, 32'hc0a80105, 1'b0, 8'h00);
    send(mk(1'b0, 32'h09090909, 8'h40));
    expect_dec(ACT_FWD_CU, inner_addr, 1'b0, 8'h00);
    send(mk(1'b1, 32'h0a560107, 8'h40));
    expect_dec(ACT_FWD_CU, inner_addr, 1'b0, 8'h00);
    @(posedge ref_clk_i) inner_en <= 1'b0;
    send(mk(1'b0, 32'h09090909, 8'h40));
    expect_dec(ACT_DROP, 32'h0, 1'b0, 8'h00);
    @(posedge ref_clk_i) inner_en <= 1'b1;
    $display("test operator ingress done");
  endtask

  task automatic t_from_cust();
    send(mk(1'b1, 32'hc0a80107, 8'h40));
    expect_dec(ACT_FWD_CU, 32'hc0a80107, 1'b0, 8'h00);
    send(mk(1'b1, 32'hc6336409, 8'h40));
    expect_dec(ACT_FWD_OP, 32'hc6336409, 1'b0, 8'h00);
    send(mk(1'b1, 32'h08080808, 8'h02));
    expect_dec(ACT_FWD_OP, default_rtr, 1'b0, 8'h00);
    send(mk(1'b1, 32'h08080808, 8'h01));
    expect_dec(ACT_DROP, 32'h0, 1'b1, ICMP_TIME_EXC);
    @(posedge ref_clk_i) def_rtr_en <= 1'b0;
    send(mk(1'b1, 32'h08080808, 8'h40));
    expect_dec(ACT_DROP, 32'h0, 1'b1, ICMP_DEST_UNR);
    $display("test customer ingress done");
  endtask

  // Runs with no default router, so every packet here but the congested one is an unroutable drop.
  task automatic t_quiet();
    pkt_desc_t  d;
    logic [7:0] err [5] = '{8'h03, 8'h04, 8'h05, 8'h0b, 8'h0c};
    for (int i = 0; i < 9; i++) begin
      d = mk(1'b1, 32'h08080808, 8'h40);
      if (i < 5) begin
        d.hdr.proto = PROTO_ICMP;
        d.icmp_type = err[i];
      end
      d.congested = (i == 5);
      if (i == 6) d.hdr.src = 32'h00000000;
      if (i == 7) d.hdr.src = 32'h7f000001;
      if (i == 8) d.hdr.frag_off = 13'h0001;
      d.hdr.csum = hdr_sum(d.hdr);
      send(d);
      expect_dec(ACT_DROP, 32'h0, 1'b0, 8'h00);
    end
    @(posedge ref_clk_i) def_rtr_en <= 1'b1;
    $display("test quiet drops done");
  endtask

  task automatic t_bcast();
    pkt_desc_t d;
    logic [31:0] dst [3] = '{32'hffffffff, 32'hc0a801ff, 32'he0000001};
    for (int i = 0; i < 4; i++) begin
      d = mk(i[0], i < 3 ? dst[i] : 32'hc0a80105, 8'h40);
      d.l2_bcast = (i == 3);
      send(d);
      expect_dec(ACT_LOCAL, 32'h0, 1'b0, 8'h00);
    end
    $display("test broadcast done");
  endtask

  task automatic t_bad_hdr();
    pkt_desc_t d;
    for (int i = 0; i < 4; i++) begin
      d = mk(1'b1, 32'h08080808, 8'h01);
      if (i == 1) d.hdr.version = 4'h6;
      if (i == 2) d.hdr.ihl = 4'h4;
      if (i == 3) d.frame_len = 16'h0010;
      d.hdr.csum = (i == 0) ? ~d.hdr.csum : hdr_sum(d.hdr);
      send(d);
      expect_dec(ACT_DROP, 32'h0, 1'b0, 8'h00);
    end
    $display("test header validation done");
  endtask

  task automatic t_reset();
    @(posedge ref_clk_i);
    reset_n_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    #1;
    chk({pkt_ready, dec_valid, ir_valid, |dec}, 4'h0);
    @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    @(posedge ref_clk_i);
    #1;
    chk({pkt_ready, ir_valid}, 2'b11);
    $display("test mid-run reset done");
  endtask

  task automatic t_inner_route();
    logic [7:0] len [5] = '{8'h28, 8'h3c, 8'h48, 8'h49, 8'h27};
    for (int i = 0; i < 7; i++) begin
      @(posedge ref_clk_i);
      lease_len <= (i < 5) ? len[i] : 8'h3c;
      link_en <= (i != 5);
      dual_mode <= (i != 6);
      repeat (2) @(posedge ref_clk_i);
      #1;
      chk(ir_valid, i < 3);
      chk(ir_nh, inner_addr);
      if (i < 3) begin
        chk(ir_prefix, {8'h0a, delegated_link_identifier, 8'h00});
        chk(ir_len, len[i] - 8'd40);
      end
    end
    $display("test inner route done");
  endtask

///////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    t_local();
    t_from_op();
    t_from_cust();
    t_quiet();
    t_bcast();
    t_bad_hdr();
    t_reset();
    t_inner_route();
    test_done();
  end
endmodule
